// file: pfp_regs.svh
// register offsets, reset values and field positions of the prefix and fetch pointer block
// assumes a 12-bit apb byte address and 32-bit data
`ifndef PFP_REGS_SVH
`define PFP_REGS_SVH

`define PFP_OFF_IP 12'h000
`define PFP_OFF_PFX 12'h004
`define PFP_OFF_STATUS 12'h008

`define PFP_RST_IP 16'h8000
`define PFP_RST_PFX 8'h00
`define PFP_RST_EXT 3'h0

`define PFP_ST_ACT_BIT 0
`define PFP_ST_EXT_LSB 8
`define PFP_ST_EXT_MSB 10

`endif

// file: pfp_pkg.sv
// types shared by the prefix and fetch pointer block
// assumes pfp_regs.svh supplies all numeric constants
package pfp_pkg;
   typedef logic [15:0] pfp_word_t;
   typedef logic [7:0] pfp_byte_t;
   typedef logic [2:0] pfp_ext_t;
   typedef enum logic [1:0] {
      PFP_APB_IDLE,
      PFP_APB_WAIT,
      PFP_APB_DONE
   } pfp_apb_st_t;
endpackage

// file: pfp_fetch_ptr.sv
// fetch address pointer: holds the next program word address
// assumes load and fetch_done are single-cycle strobes on the core clock
`timescale 1ns/10ps
`include "pfp_regs.svh"
module pfp_fetch_ptr
   import pfp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fetch_done,
   input wire logic load,
   input wire pfp_word_t load_addr,
   output pfp_word_t fetch_address_pointer_q
);
   pfp_word_t fetch_address_pointer_d;

   always_comb begin
      fetch_address_pointer_d = fetch_address_pointer_q;
      // [RL9] write redirects fetch
      if (load) begin
         fetch_address_pointer_d = load_addr;
      // [RL8] advance after fetch
      end else if (fetch_done) begin
         fetch_address_pointer_d = fetch_address_pointer_q + 16'h0001;
      end
   end

   // [RL7] reset to program start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_address_pointer_q <= `PFP_RST_IP;
      end else begin
         fetch_address_pointer_q <= fetch_address_pointer_d;
      end
   end
endmodule // pfp_fetch_ptr

// file: pfp_top.sv
// prefix register and fetch address pointer with an apb register port
// assumes core strobes arrive on pclk, one cycle wide, no synchronisers needed
//
// What this block does
// [RL1] prefix clears to zero on reset
// [RL2] prefix joins byte source as upper byte
// [RL3] prefix lives one instruction, then clears
// [RL4] unloaded prefix read as source gives zero
// [RL5] prefix upper eight bits read zero
// [RL6] subdecodes one to seven extend indexing
// [RL7] pointer resets to program start address
// [RL8] pointer holds next address, increments per fetch
// [RL9] pointer write redirects the fetch stream
// [RL10] pointer read leaves fetching untouched
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "pfp_regs.svh"
module pfp_top
   import pfp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic instr_step,
   input wire logic fetch_done,
   input wire logic core_ip_we,
   input wire pfp_word_t core_ip_wdata,
   input wire logic core_pfx_we,
   input wire pfp_byte_t core_pfx_wdata,
   input wire pfp_ext_t core_pfx_sel,
   input wire pfp_byte_t src_operand,
   output pfp_word_t fetch_addr,
   output pfp_byte_t pfx_source,
   output pfp_ext_t idx_ext,
   output pfp_word_t dest_data,
   output logic dest_valid
);

   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
      addr_hit = (a[11:2] == off[11:2]);
   endfunction

   function automatic pfp_word_t lane_merge(input pfp_word_t old_v, input logic [31:0] wd,
                                           input logic [3:0] be);
      pfp_word_t r;
      r = old_v;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      lane_merge = r;
   endfunction

   // apb handshake state
   pfp_apb_st_t apb_st_q;
   pfp_apb_st_t apb_st_d;
   logic pready_q;
   logic pready_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pslverr_q;
   logic pslverr_d;

   // prefix state
   pfp_byte_t pfx_q;
   pfp_byte_t pfx_d;
   pfp_ext_t ext_q;
   pfp_ext_t ext_d;
   logic pfx_act_q;
   logic pfx_act_d;

   // merged destination
   pfp_word_t dest_q;
   pfp_word_t dest_d;
   logic dest_vld_q;
   logic dest_vld_d;

   // decoded access
   logic apb_done;
   logic hit_ip;
   logic hit_pfx;
   logic hit_st;
   logic mapped;
   logic apb_ip_we;
   logic apb_pfx_we;
   logic ip_load;
   pfp_word_t ip_load_addr;
   pfp_word_t ip_q;
   pfp_word_t ip_wr_val;

   assign hit_ip = addr_hit(paddr, `PFP_OFF_IP);
   assign hit_pfx = addr_hit(paddr, `PFP_OFF_PFX);
   assign hit_st = addr_hit(paddr, `PFP_OFF_STATUS);
   assign mapped = hit_ip | hit_pfx | hit_st;

   // the transfer completes only on the edge where pready is seen high
   assign apb_done = psel & penable & pready_q;
   assign apb_ip_we = apb_done & pwrite & hit_ip;
   assign apb_pfx_we = apb_done & pwrite & hit_pfx & pstrb[0];
   assign ip_wr_val = lane_merge(ip_q, pwdata, pstrb);

   // core branch wins over a simultaneous bus write; both are redirects
   always_comb begin
      ip_load = 1'b0;
      ip_load_addr = ip_q;
      // [RL9] branch on pointer write
      if (core_ip_we) begin
         ip_load = 1'b1;
         ip_load_addr = core_ip_wdata;
      end else if (apb_ip_we) begin
         ip_load = 1'b1;
         ip_load_addr = ip_wr_val;
      end
   end

   pfp_fetch_ptr u_fetch_ptr (
      .clk(pclk),
      .rst_n(presetn),
      .fetch_done(fetch_done),
      .load(ip_load),
      .load_addr(ip_load_addr),
      .fetch_address_pointer_q(ip_q)
   );

   // apb slave: one wait cycle so every answer comes from a flop
   always_comb begin
      apb_st_d = apb_st_q;
      pready_d = 1'b0;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      case (apb_st_q)
         PFP_APB_IDLE: begin
            if (psel && penable) begin
               apb_st_d = PFP_APB_WAIT;
               pready_d = 1'b1;
               pslverr_d = ~mapped;
               prdata_d = 32'h0000_0000;
               if (!pwrite) begin
                  // [RL10] plain read of pointer
                  if (hit_ip) begin
                     prdata_d = {16'h0000, ip_q};
                  end
                  // [RL5] upper prefix bits zero
                  if (hit_pfx) begin
                     prdata_d = {24'h00_0000, pfx_q};
                  end
                  if (hit_st) begin
                     prdata_d[`PFP_ST_ACT_BIT] = pfx_act_q;
                     prdata_d[`PFP_ST_EXT_MSB:`PFP_ST_EXT_LSB] = ext_q;
                  end
               end
            end
         end
         PFP_APB_WAIT: begin
            apb_st_d = PFP_APB_DONE;
         end
         PFP_APB_DONE: begin
            apb_st_d = PFP_APB_IDLE;
         end
         default: begin
            apb_st_d = PFP_APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_st_q <= PFP_APB_IDLE;
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         apb_st_q <= apb_st_d;
         pready_q <= pready_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // prefix: a load arms it, the next instruction boundary consumes it
   always_comb begin
      pfx_d = pfx_q;
      ext_d = ext_q;
      pfx_act_d = pfx_act_q;
      // [RL3] auto clear after one instruction
      if (instr_step) begin
         pfx_d = `PFP_RST_PFX;
         ext_d = `PFP_RST_EXT;
         pfx_act_d = 1'b0;
      end
      // load beats the clear so a back-to-back prefix is not lost
      if (core_pfx_we) begin
         pfx_d = core_pfx_wdata;
         // [RL6] subdecode as index extension
         ext_d = core_pfx_sel;
         pfx_act_d = 1'b1;
      end else if (apb_pfx_we) begin
         pfx_d = pwdata[7:0];
         ext_d = `PFP_RST_EXT;
         pfx_act_d = 1'b1;
      end
   end

   // [RL1] prefix cleared on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pfx_q <= `PFP_RST_PFX;
         ext_q <= `PFP_RST_EXT;
         pfx_act_q <= 1'b0;
      end else begin
         pfx_q <= pfx_d;
         ext_q <= ext_d;
         pfx_act_q <= pfx_act_d;
      end
   end

   // destination word of the instruction ending at this boundary
   always_comb begin
      dest_d = dest_q;
      dest_vld_d = 1'b0;
      if (instr_step) begin
         dest_vld_d = 1'b1;
         // [RL2] prefix as upper byte
         if (pfx_act_q) begin
            dest_d = {pfx_q, src_operand};
         // [RL4] inactive prefix yields zero
         end else begin
            dest_d = {8'h00, src_operand};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dest_q <= 16'h0000;
         dest_vld_q <= 1'b0;
      end else begin
         dest_q <= dest_d;
         dest_vld_q <= dest_vld_d;
      end
   end

   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign fetch_addr = ip_q;
   // [RL4] source view is zero unless armed
   assign pfx_source = pfx_q;
   assign idx_ext = ext_q;
   assign dest_data = dest_q;
   assign dest_valid = dest_vld_q;

endmodule // pfp_top

// file: pfp_top_asserts.sv
// concurrent checks on the prefix and fetch pointer ports
// assumes pfp_top runs on pclk with presetn active low
`timescale 1ns/10ps
module pfp_top_asserts
   import pfp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic instr_step,
   input wire logic fetch_done,
   input wire logic core_ip_we,
   input wire pfp_word_t core_ip_wdata,
   input wire logic core_pfx_we,
   input wire pfp_byte_t core_pfx_wdata,
   input wire pfp_ext_t core_pfx_sel,
   input wire pfp_byte_t src_operand,
   input wire pfp_word_t fetch_addr,
   input wire pfp_byte_t pfx_source,
   input wire pfp_ext_t idx_ext,
   input wire pfp_word_t dest_data,
   input wire logic dest_valid
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RESET_VALUES: assert property ($rose(presetn) |-> fetch_addr == 16'h8000 &&
      pfx_source == 8'h00) else $error("reset values wrong");
   AST_FETCH_INC: assert property (fetch_done && !core_ip_we && !pready |=>
      fetch_addr == $past(fetch_addr) + 16'h0001) else $error("pointer did not advance");
   AST_BRANCH: assert property (core_ip_we |=> fetch_addr == $past(core_ip_wdata))
      else $error("branch not taken");
   AST_HOLD: assert property (!fetch_done && !core_ip_we && !pready |=> $stable(fetch_addr))
      else $error("pointer moved without cause");
   AST_PREFIX_LOAD: assert property (core_pfx_we |=> pfx_source == $past(core_pfx_wdata) &&
      idx_ext == $past(core_pfx_sel)) else $error("prefix load wrong");
   AST_PREFIX_CLEAR: assert property (instr_step && !core_pfx_we && !pready |=>
      pfx_source == 8'h00 && idx_ext == 3'h0) else $error("prefix not cleared");
   AST_JOIN: assert property (instr_step |=> dest_valid &&
      dest_data == {$past(pfx_source), $past(src_operand)}) else $error("joined word wrong");
   AST_PULSE: assert property (dest_valid |-> $past(instr_step))
      else $error("stray result strobe");
   cover property (fetch_done ##1 fetch_done);
   cover property (core_pfx_we ##[1:3] instr_step);
   cover property (pready && pslverr);
endmodule // pfp_top_asserts

bind pfp_top pfp_top_asserts u_chk (.*);

// file: pfp_top_test.sv
// self-checking bench for pfp_top: apb master, core strobes, random stimulus
// assumes the one-wait-state apb slave and core strobe timing of the block
`timescale 1ns/10ps
module pfp_top_test;
   import pfp_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, rnd;
   logic [3:0] pstrb;
   logic instr_step, fetch_done, core_ip_we, core_pfx_we, dest_valid;
   pfp_word_t core_ip_wdata, fetch_addr, dest_data, ex;
   pfp_byte_t core_pfx_wdata, src_operand, pfx_source;
   pfp_ext_t core_pfx_sel, idx_ext;
   int miscompares = 0, n_compared = 0;
   pfp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .instr_step(instr_step), .fetch_done(fetch_done),
      .core_ip_we(core_ip_we), .core_ip_wdata(core_ip_wdata), .core_pfx_we(core_pfx_we),
      .core_pfx_wdata(core_pfx_wdata), .core_pfx_sel(core_pfx_sel),
      .src_operand(src_operand), .fetch_addr(fetch_addr), .pfx_source(pfx_source),
      .idx_ext(idx_ext), .dest_data(dest_data), .dest_valid(dest_valid));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report;
      if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no own limit: only the watchdog ends a hung transfer
      do begin @(posedge pclk); end while (pready !== 1'b1);
      r = prdata; se = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      #1;
   endtask
   task automatic core(input logic f, b, l, s, input pfp_word_t bw, input pfp_byte_t lw, sw,
                       input pfp_ext_t sl);
      @(posedge pclk);
      fetch_done <= f; core_ip_we <= b; core_ip_wdata <= bw; core_pfx_we <= l;
      core_pfx_wdata <= lw; core_pfx_sel <= sl; instr_step <= s; src_operand <= sw;
      @(posedge pclk);
      {fetch_done, core_ip_we, core_pfx_we, instr_step} <= 4'h0;
      #1;
   endtask
   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      final_report;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, instr_step, fetch_done} = '0;
      {core_ip_we, core_ip_wdata, core_pfx_we, core_pfx_wdata, core_pfx_sel, src_operand} = '0;
      pstrb = 4'hf;
      rnd = 32'h8f65;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0000_0000); chk("ptr_read", 32'h0000_8000, r);
      apb(1'b0, 12'h004, 32'h0000_0000); chk("prefix_read", 32'h0000_0000, r);
      ex = 16'h8000;
      for (int k = 0; k < 24; k++) begin
         rnd = nx(rnd);
         core(rnd[0], rnd[3] & rnd[4], 1'b0, 1'b0, rnd[31:16], 8'h00, 8'h00, 3'h0);
         ex = (rnd[3] & rnd[4]) ? rnd[31:16] : ex + {15'h0000, rnd[0]};
         chk("fetch_addr", {16'h0000, ex}, {16'h0000, fetch_addr});
      end
      rnd = nx(rnd);
      apb(1'b1, 12'h000, rnd); ex = rnd[15:0];
      chk("fetch_addr", {16'h0000, ex}, {16'h0000, fetch_addr});
      apb(1'b0, 12'h000, 32'h0000_0000); chk("ptr_read", {16'h0000, ex}, r);
      chk("fetch_addr", {16'h0000, ex}, {16'h0000, fetch_addr});
      for (int s = 1; s < 8; s++) begin
         rnd = nx(rnd);
         core(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, rnd[7:0], 8'h00, 3'(s));
         chk("idx_ext", 32'(s), {29'h0000_0000, idx_ext});
         core(1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 8'h00, rnd[15:8], 3'h0);
         chk("dest_data", {16'h0000, rnd[7:0], rnd[15:8]}, {16'h0000, dest_data});
         chk("dest_valid", 32'h0000_0001, {31'h0, dest_valid});
         chk("prefix", 32'h0000_0000, {21'h00_0000, idx_ext, pfx_source});
         core(1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 8'h00, rnd[23:16], 3'h0);
         chk("dest_data", {24'h00_0000, rnd[23:16]}, {16'h0000, dest_data});
      end
      apb(1'b1, 12'h004, 32'hffff_ff5a);
      apb(1'b0, 12'h004, 32'h0000_0000); chk("prefix_read", 32'h0000_005a, r);
      apb(1'b0, 12'h008, 32'h0000_0000); chk("status_read", 32'h0000_0001, r);
      apb(1'b1, 12'hff0, 32'h0000_1111); chk("pslverr", 32'h0000_0001, {31'h0, se});
      chk("fetch_addr", {16'h0000, ex}, {16'h0000, fetch_addr});
      final_report;
   end
endmodule // pfp_top_test
